//--- rtl/ccdls_pkg.sv
// Package: constants and carrier types of the CCD line sequencer
// What this block does
// - Pixel word presented at fixed moment
// - Reset pulse splits signal and reference portions
// - Reference sampled just before next phase edge
// - Transfer width and guardband at least 20
// - Polarity bit one inverts transfer or reset
// - Power-down drives sensor clocks low
package ccdls_pkg;
    localparam int PIX_PERIOD = 16;
    localparam int POS_W = 4;
    localparam int PHI_HALF = 8;
    localparam int TR_MIN_MCLK = 20;
    localparam int GUARD_MIN_MCLK = 20;
    localparam int CNT_W = 12;
    localparam int DATA_W = 8;
    localparam logic [DATA_W-1:0] PIX_RESET = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;

    typedef struct packed {
        logic even_odd;
        logic [3:0] rs_pos;
        logic [1:0] rs_width;
        logic [3:0] ref_pos;
        logic [3:0] sig_pos;
        logic [7:0] tr_width;
        logic [7:0] guard;
        logic tr_inv;
        logic rs_inv;
        logic sig_inv;
        logic [3:0] clk_en;
        logic power_down;
        logic [7:0] dummy;
        logic [7:0] black;
        logic [11:0] line_len;
    } ccdls_cfg_t;

    typedef struct packed {
        logic first;
        logic [7:0] data;
    } ccdls_pix_t;
endpackage

//--- rtl/ccdls_buf.sv
// Two-entry pixel buffer with valid/ready on both sides
`timescale 1ns/1ps
module ccdls_buf (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // Filling side
    input wire logic i_in_valid,
    input wire ccdls_pkg::ccdls_pix_t i_in_pix,
    output logic o_in_ready,
    // Draining side
    output logic o_out_valid,
    output ccdls_pkg::ccdls_pix_t o_out_pix,
    input wire logic i_out_ready
);
    logic skid_v;
    ccdls_pkg::ccdls_pix_t skid_d;
    logic next_out_v;
    logic next_skid_v;
    ccdls_pkg::ccdls_pix_t next_out_d;
    ccdls_pkg::ccdls_pix_t next_skid_d;

    assign o_in_ready = ~skid_v;

    always_comb begin
        next_out_v = o_out_valid;
        next_out_d = o_out_pix;
        next_skid_v = skid_v;
        next_skid_d = skid_d;
        if (o_out_valid && i_out_ready) begin
            next_out_v = skid_v;
            next_out_d = skid_d;
            next_skid_v = 1'b0;
        end
        if (i_in_valid && !skid_v) begin
            if (!next_out_v) begin
                next_out_v = 1'b1;
                next_out_d = i_in_pix;
            end else begin
                next_skid_v = 1'b1;
                next_skid_d = i_in_pix;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_out_valid <= 1'b0;
            o_out_pix <= '0;
            skid_v <= 1'b0;
            skid_d <= '0;
        end else if (i_ce) begin
            o_out_valid <= next_out_v;
            o_out_pix <= next_out_d;
            skid_v <= next_skid_v;
            skid_d <= next_skid_d;
        end
    end

    hold_word_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_pix))
        else $error("stalled pixel word changed");
endmodule

//--- rtl/ccdls_top.sv
// Line sequencer: sensor clocks, transfer, sampling, pixel output
`timescale 1ns/1ps
module ccdls_top (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // Configuration
    input wire ccdls_pkg::ccdls_cfg_t i_cfg,
    // Line sync and converter pins
    input wire logic i_line_sync,
    input wire logic [7:0] i_adc_data,
    // Sensor clocks
    output logic o_phi1,
    output logic o_phi2,
    output logic o_sensor_reset_pulse,
    output logic o_transfer_pulse,
    // Status
    output logic o_line_busy,
    output logic o_line_done,
    // Pixel stream
    output logic o_pix_valid,
    output ccdls_pkg::ccdls_pix_t o_pix,
    input wire logic i_pix_ready
);
    typedef enum {ST_IDLE, ST_GUARD1, ST_XFER, ST_GUARD2, ST_PIX} ccdls_st_t;

    localparam logic [3:0] POS_END = 4'(ccdls_pkg::PIX_PERIOD - 1);
    localparam logic [3:0] PHI_HALF = 4'(ccdls_pkg::PHI_HALF);

    // Pin synchronisers
    logic [2:0] sync_sh;
    logic sync_lvl;
    logic [7:0] adc_s1;
    logic [7:0] adc_s2;
    logic [7:0] adc_s3;
    logic [7:0] adc_q;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync_sh <= 3'h0;
            sync_lvl <= 1'b0;
            adc_s1 <= 8'h00;
            adc_s2 <= 8'h00;
            adc_s3 <= 8'h00;
        end else if (i_ce) begin
            sync_sh <= {sync_sh[1:0], i_line_sync};
            if (sync_sh[1] == sync_sh[2]) begin
                sync_lvl <= sync_sh[2];
            end
            adc_s1 <= i_adc_data;
            adc_s2 <= adc_s1;
            adc_s3 <= adc_s2;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_adc
            always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    adc_q[gi] <= 1'b0;
                end else if (i_ce && adc_s2[gi] == adc_s3[gi]) begin
                    adc_q[gi] <= adc_s3[gi];
                end
            end
        end
    endgenerate

    logic line_start;
    assign line_start = sync_sh[1] & sync_sh[2] & ~sync_lvl;

    // Sequencer state
    ccdls_st_t st;
    ccdls_st_t next_st;
    logic [3:0] pos;
    logic [3:0] next_pos;
    logic [11:0] cnt;
    logic [11:0] next_cnt;
    logic [11:0] pix_idx;
    logic [11:0] next_pix_idx;
    logic [7:0] ref_smp;
    logic [7:0] next_ref_smp;
    logic [7:0] sig_smp;
    logic [7:0] next_sig_smp;
    logic next_done;

    logic [11:0] tr_last;
    logic [11:0] guard_last;
    logic [11:0] skip;
    logic push;
    logic buf_ready;
    logic adv;
    ccdls_pkg::ccdls_pix_t push_pix;

    assign tr_last = 12'(ccdls_pkg::TR_MIN_MCLK) + {4'h0, i_cfg.tr_width}
        - 12'h001;
    assign guard_last = 12'(ccdls_pkg::GUARD_MIN_MCLK) + {4'h0, i_cfg.guard}
        - 12'h001;
    assign skip = {4'h0, i_cfg.dummy} - 12'h001 + {4'h0, i_cfg.black};
    // Power-down must never wait on a full buffer
    assign push = (st == ST_PIX) && (pos == POS_END) && (pix_idx >= skip)
        && !i_cfg.power_down;
    assign adv = i_ce & ~(push & ~buf_ready);

    always_comb begin
        push_pix.first = (pix_idx == skip);
        if (i_cfg.sig_inv) begin
            push_pix.data = (ref_smp > sig_smp) ? ref_smp - sig_smp
                : ccdls_pkg::PIX_RESET;
        end else begin
            push_pix.data = (sig_smp > ref_smp) ? sig_smp - ref_smp
                : ccdls_pkg::PIX_RESET;
        end
    end

    always_comb begin
        next_st = st;
        next_pos = pos;
        next_cnt = cnt;
        next_pix_idx = pix_idx;
        next_ref_smp = ref_smp;
        next_sig_smp = sig_smp;
        next_done = 1'b0;
        case (st)
            ST_IDLE: begin
                if (line_start && !i_cfg.power_down) begin
                    next_st = ST_GUARD1;
                    next_cnt = ccdls_pkg::CNT_RESET;
                end
            end
            ST_GUARD1: begin
                next_cnt = cnt + 12'h001;
                if (cnt == guard_last) begin
                    next_st = ST_XFER;
                    next_cnt = ccdls_pkg::CNT_RESET;
                end
            end
            ST_XFER: begin
                next_cnt = cnt + 12'h001;
                if (cnt == tr_last) begin
                    next_st = ST_GUARD2;
                    next_cnt = ccdls_pkg::CNT_RESET;
                end
            end
            ST_GUARD2: begin
                next_cnt = cnt + 12'h001;
                if (cnt == guard_last) begin
                    next_st = ST_PIX;
                    next_pos = 4'h0;
                    next_pix_idx = ccdls_pkg::CNT_RESET;
                end
            end
            ST_PIX: begin
                next_pos = pos + 4'h1;
                if (pos == i_cfg.ref_pos) begin
                    next_ref_smp = adc_q;
                end
                if (pos == i_cfg.sig_pos) begin
                    next_sig_smp = adc_q;
                end
                if (pos == POS_END) begin
                    next_pos = 4'h0;
                    next_pix_idx = pix_idx + 12'h001;
                    if (pix_idx == i_cfg.line_len - 12'h001) begin
                        next_st = ST_IDLE;
                        next_done = 1'b1;
                    end
                end
            end
            default: begin
                next_st = ST_IDLE;
            end
        endcase
        if (i_cfg.power_down) begin
            next_st = ST_IDLE;
        end
    end

    // Sensor clock shaping
    logic phi_lvl;
    logic rs_act;
    logic [4:0] rs_end;
    logic next_phi1;
    logic next_phi2;
    logic next_rs;
    logic next_tr;

    assign rs_end = {1'b0, i_cfg.rs_pos} + 5'(i_cfg.rs_width) + 5'h01;

    always_comb begin
        if (next_st != ST_PIX) begin
            phi_lvl = 1'b1;
        end else if (i_cfg.even_odd) begin
            phi_lvl = ~next_pix_idx[0];
        end else begin
            phi_lvl = next_pos < PHI_HALF;
        end
        rs_act = (next_st == ST_PIX) && (next_pos >= i_cfg.rs_pos)
            && ({1'b0, next_pos} < rs_end);
        next_phi1 = ~i_cfg.power_down & i_cfg.clk_en[0] & phi_lvl;
        next_phi2 = ~i_cfg.power_down & i_cfg.clk_en[1] & ~phi_lvl;
        next_rs = ~i_cfg.power_down & i_cfg.clk_en[2]
            & (rs_act ^ i_cfg.rs_inv);
        next_tr = ~i_cfg.power_down & i_cfg.clk_en[3]
            & ((next_st == ST_XFER) ^ i_cfg.tr_inv);
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= ST_IDLE;
            pos <= 4'h0;
            cnt <= ccdls_pkg::CNT_RESET;
            pix_idx <= ccdls_pkg::CNT_RESET;
            ref_smp <= ccdls_pkg::PIX_RESET;
            sig_smp <= ccdls_pkg::PIX_RESET;
            o_line_done <= 1'b0;
            o_line_busy <= 1'b0;
            o_phi1 <= 1'b0;
            o_phi2 <= 1'b0;
            o_sensor_reset_pulse <= 1'b0;
            o_transfer_pulse <= 1'b0;
        end else if (adv) begin
            st <= next_st;
            pos <= next_pos;
            cnt <= next_cnt;
            pix_idx <= next_pix_idx;
            ref_smp <= next_ref_smp;
            sig_smp <= next_sig_smp;
            o_line_done <= next_done;
            o_line_busy <= next_st != ST_IDLE;
            o_phi1 <= next_phi1;
            o_phi2 <= next_phi2;
            o_sensor_reset_pulse <= next_rs;
            o_transfer_pulse <= next_tr;
        end else if (i_ce) begin
            o_line_done <= 1'b0;
        end
    end

    // Output word buffer; stalls the sequencer when full
    ccdls_buf u_buf (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_in_valid(push & i_ce),
        .i_in_pix(push_pix),
        .o_in_ready(buf_ready),
        .o_out_valid(o_pix_valid),
        .o_out_pix(o_pix),
        .i_out_ready(i_pix_ready)
    );

    // Checks
    logic [11:0] xfer_len;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            xfer_len <= 12'h000;
        end else if (adv) begin
            xfer_len <= (st == ST_XFER) ? xfer_len + 12'h001 : 12'h000;
        end
    end

    xfer_width_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        (st == ST_XFER) && adv && (next_st != ST_XFER) && !i_cfg.power_down
        |-> xfer_len >= 12'(ccdls_pkg::TR_MIN_MCLK - 1))
        else $error("transfer pulse shorter than minimum");

    guard_len_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        (st == ST_GUARD2) && adv && (next_st == ST_PIX)
        |-> cnt >= 12'(ccdls_pkg::GUARD_MIN_MCLK - 1))
        else $error("guardband shorter than minimum");

    rs_place_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        (st == ST_PIX) && adv && (next_st == ST_PIX)
        && (next_pos == i_cfg.rs_pos) && i_cfg.clk_en[2]
        && !i_cfg.power_down |=> o_sensor_reset_pulse != i_cfg.rs_inv)
        else $error("reset pulse missing at its position");

    ref_sample_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        (st == ST_PIX) && (pos == i_cfg.ref_pos) && adv
        |=> ref_smp == $past(adc_q))
        else $error("reference not sampled at its position");

    tr_polarity_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        adv && (next_st == ST_XFER) && i_cfg.clk_en[3] && !i_cfg.power_down
        |=> o_transfer_pulse == !i_cfg.tr_inv)
        else $error("transfer polarity wrong");

    pd_clocks_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        i_cfg.power_down && i_ce ##1 i_cfg.power_down && i_ce
        |-> !o_phi1 && !o_phi2 && !o_sensor_reset_pulse
        && !o_transfer_pulse)
        else $error("sensor clocks not low in power-down");

    word_out_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        push && adv |=> o_pix_valid)
        else $error("pixel word not presented");

    stall_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        push && i_ce && !buf_ready |=> $stable(pos) && $stable(pix_idx))
        else $error("sequencer moved while buffer full");
endmodule

//--- verification/ccdls_sensor_model.sv
// Sensor model: output levels, colour counter and transfer demux
`timescale 1ns/1ps
module ccdls_sensor_model (
    // Clock, sensor clocks, line done and reset polarity
    input wire logic i_ref_clk,
    input wire logic i_phi1,
    input wire logic i_sensor_reset_pulse,
    input wire logic i_transfer_pulse,
    input wire logic i_line_done,
    input wire logic i_rs_inv,
    // Levels of this line
    input wire logic [7:0] i_sig,
    input wire logic [7:0] i_ref,
    // Converter word and transfer gates
    output logic [7:0] o_adc_data,
    output logic [2:0] o_tr_gate
);
    logic phi_q = 1'b0;
    logic in_ref = 1'b0;
    logic [1:0] colour = 2'h0;
    always @(posedge i_ref_clk) begin
        phi_q <= i_phi1;
        if (i_phi1 != phi_q) begin
            in_ref <= 1'b0;
        end else if ((i_sensor_reset_pulse ^ i_rs_inv) == 1'b1) begin
            in_ref <= 1'b1;
        end
        // Selection steps only between lines
        if (i_line_done) begin
            colour <= (colour == 2'h2) ? 2'h0 : colour + 2'h1;
        end
    end
    // Level follows the reset gate and phase edge at once
    logic rs_now;
    assign rs_now = i_sensor_reset_pulse ^ i_rs_inv;
    assign o_adc_data = (rs_now || (in_ref && i_phi1 == phi_q)) ? i_ref
        : i_sig;
    assign o_tr_gate = i_transfer_pulse ? (3'h1 << colour) : 3'h0;
endmodule

//--- verification/ccdls_top_tb.sv
// Self-checking bench of the line sequencer
`timescale 1ns/1ps
module ccdls_top_tb;
    logic i_ref_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_line_sync = 1'b0;
    logic i_pix_ready = 1'b1;
    ccdls_pkg::ccdls_cfg_t cfg = '0;
    logic [7:0] adc;
    logic [7:0] sig = 8'h00;
    logic [7:0] ref_lvl = 8'h00;
    logic phi1, phi2, rsp, trp, busy, done, pvalid;
    ccdls_pkg::ccdls_pix_t pix;
    ccdls_pkg::ccdls_pix_t last_pix;
    ccdls_pkg::ccdls_pix_t expq[$];
    int n_errors = 0;
    int samples_checked = 0;
    int rs_run = 0;
    int tr_run = 0;
    int cyc = 0;
    logic [31:0] seed = 32'he04d;
    logic [31:0] rseed = 32'he04d;
    logic chk_on = 1'b0;
    logic chk_pix = 1'b1;
    logic stall = 1'b0;
    logic held = 1'b0;

    ccdls_top ccdls_top_inst (
        // One master clock and sync for the device
        .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_ce(1'b1),
        .i_cfg(cfg), .i_line_sync(i_line_sync), .i_adc_data(adc),
        .o_phi1(phi1), .o_phi2(phi2), .o_sensor_reset_pulse(rsp),
        .o_transfer_pulse(trp), .o_line_busy(busy), .o_line_done(done),
        .o_pix_valid(pvalid), .o_pix(pix), .i_pix_ready(i_pix_ready)
    );
    ccdls_sensor_model ccdls_sensor_model_inst (
        .i_ref_clk(i_ref_clk), .i_phi1(phi1),
        .i_sensor_reset_pulse(rsp), .i_transfer_pulse(trp),
        .i_line_done(done), .i_rs_inv(cfg.rs_inv), .i_sig(sig),
        .i_ref(ref_lvl), .o_adc_data(adc), .o_tr_gate()
    );

    initial begin
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("Checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #2;
    endtask

    // Receiver: long refusals fill the buffer and freeze the line
    always @(posedge i_ref_clk) begin
        #2;
        rseed = xorshift(rseed);
        cyc++;
        i_pix_ready = !stall || (cyc[6] && rseed[0]);
    end

    // Output monitor: pulse widths, held words, word stream
    always @(posedge i_ref_clk) begin
        if (chk_on && busy === 1'b1) begin
            if ((rsp ^ cfg.rs_inv) === 1'b1) begin
                rs_run <= rs_run + 1;
            end else begin
                if (rs_run > 0) check("reset width", rs_run, cfg.rs_width + 1);
                rs_run <= 0;
            end
            if ((trp ^ cfg.tr_inv) === 1'b1) begin
                tr_run <= tr_run + 1;
            end else begin
                if (tr_run > 0) check("transfer width", tr_run, ccdls_pkg::TR_MIN_MCLK + cfg.tr_width);
                tr_run <= 0;
            end
        end else begin
            rs_run <= 0;
            tr_run <= 0;
        end
        if (held) begin
            check("held valid", pvalid, 1'b1);
            check("held word", pix, last_pix);
        end
        held <= chk_pix && pvalid === 1'b1 && i_pix_ready !== 1'b1;
        last_pix <= pix;
        if (chk_pix && pvalid === 1'b1 && i_pix_ready === 1'b1) begin
            if (expq.size() == 0) check("extra word", 1'b1, 1'b0);
            else check("pixel word", pix, expq.pop_front());
        end
    end

    task automatic run_line(input logic [7:0] s, input logic [7:0] r);
        ccdls_pkg::ccdls_pix_t e;
        int n;
        sig = s;
        ref_lvl = r;
        n = int'(cfg.line_len) - int'(cfg.dummy) + 1 - int'(cfg.black);
        for (int k = 0; k < n; k++) begin
            e.first = (k == 0);
            if (cfg.sig_inv) e.data = (r > s) ? r - s : 8'h00;
            else e.data = (s > r) ? s - r : 8'h00;
            expq.push_back(e);
        end
        i_line_sync = 1'b1;
        n = 0;
        while (busy !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        i_line_sync = 1'b0;
        check("busy", busy, 1'b1);
        n = 0;
        while (done !== 1'b1 && n < 4000) begin
            tick(1);
            n++;
            // Sync raised mid-line must be ignored
            if (n == 100) i_line_sync = 1'b1;
            if (n == 140) i_line_sync = 1'b0;
        end
        check("done", done, 1'b1);
        if (n >= 4000) end_of_test();
        tick(5);
        check("idle after line", busy, 1'b0);
        check("transfer idle", trp, cfg.tr_inv);
        $display("Line test done");
    endtask

    initial begin
        int n;
        // Host setup for an even/odd sensor
        cfg.even_odd = 1'b1;
        cfg.rs_pos = 4'ha;
        cfg.ref_pos = 4'he;
        cfg.sig_pos = 4'h8;
        cfg.clk_en = 4'hf;
        cfg.dummy = 8'h02;
        cfg.black = 8'h05;
        cfg.power_down = 1'b0;
        cfg.line_len = 12'h007;
        tick(3);
        check("reset outputs", {phi1, phi2, rsp, trp, busy, pvalid}, 6'h00);
        i_arst_n = 1'b1;
        chk_on = 1'b1;
        for (int t = 0; t < 6; t++) begin
            seed = xorshift(seed);
            cfg.tr_width = {4'h0, seed[3:0]};
            cfg.guard = {4'h0, seed[7:4]};
            cfg.rs_width = seed[9:8];
            cfg.tr_inv = seed[10];
            cfg.rs_inv = seed[11];
            cfg.sig_inv = seed[15];
            // Settings change only between lines
            if (t > 0) cfg.line_len = 12'h007 + seed[14:12];
            stall = (t > 1);
            tick(2);
            run_line(seed[23:16], seed[31:24]);
        end
        stall = 1'b0;
        n = 0;
        while (expq.size() > 0 && n < 500) begin
            tick(1);
            n++;
        end
        check("words left", expq.size(), 0);
        // Power-down in mid-line with inverted pulses
        chk_pix = 1'b0;
        cfg.rs_inv = 1'b1;
        cfg.tr_inv = 1'b1;
        tick(2);
        i_line_sync = 1'b1;
        tick(60);
        chk_on = 1'b0;
        cfg.power_down = 1'b1;
        tick(1);
        for (int k = 0; k < 4; k++) begin
            check("standby clocks", {phi1, phi2, rsp, trp}, 4'h0);
            tick(1);
        end
        $display("Power-down test done");
        end_of_test();
    end
endmodule
